/* File: rtl/bwd_pkg.sv */
package bwd_pkg;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam int AXI_ADDR_W = 12;
    localparam logic [7:0] IDX_WIN0_BASE = 8'h44;
    localparam logic [7:0] IDX_WIN0_LIMIT = 8'h48;
    localparam logic [7:0] IDX_WIN1_BASE = 8'h4c;
    localparam logic [7:0] IDX_WIN1_LIMIT = 8'h50;
    localparam logic [7:0] IDX_WIN_ENABLE = 8'h54;
    localparam logic [7:0] IDX_WIN_MAP = 8'h55;
    localparam logic [7:0] IDX_SEC_DECODE = 8'h56;
    localparam logic [11:0] ADDR_WIN0_BASE = {2'h0, IDX_WIN0_BASE, 2'h0};
    localparam logic [11:0] ADDR_WIN0_LIMIT = {2'h0, IDX_WIN0_LIMIT, 2'h0};
    localparam logic [11:0] ADDR_WIN1_BASE = {2'h0, IDX_WIN1_BASE, 2'h0};
    localparam logic [11:0] ADDR_WIN1_LIMIT = {2'h0, IDX_WIN1_LIMIT, 2'h0};
    localparam logic [11:0] ADDR_WIN_ENABLE = {2'h0, IDX_WIN_ENABLE, 2'h0};
    localparam logic [11:0] ADDR_WIN_MAP = {2'h0, IDX_WIN_MAP, 2'h0};
    localparam logic [11:0] ADDR_SEC_DECODE = {2'h0, IDX_SEC_DECODE, 2'h0};
    localparam logic [11:0] ADDR_DEC_STATUS = 12'h180;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] RST_WIN_ENABLE = 2'h0;
    localparam logic [1:0] RST_WIN_MAP = 2'h0;
    localparam logic [2:0] RST_SEC_DECODE = 3'h6;
    localparam logic [31:0] RST_WIN_ADDR = 32'h0;
    localparam int SEC_SUB_EN_BIT = 0;
    localparam int SEC_NEG_EN_BIT = 1;
    localparam int SEC_SLOW_BIT = 2;
    localparam int LIMIT_PF_BIT = 0;
    localparam int LIMIT_IO_BIT = 1;
    localparam logic [31:0] BASE_RO_MASK = 32'hffff_fffc;
    localparam logic [2:0] SLOT_SLOW_CLKS = 3'h4;
    localparam logic [2:0] SLOT_NORMAL_CLKS = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic is_io;
        logic [31:0] addr;
    } bwd_txn_s;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] limit;
    } bwd_window_s;

    typedef enum logic [2:0] {
        SUB_IDLE = 3'b001,
        SUB_WAIT = 3'b010,
        SUB_HOLD = 3'b100
    } bwd_sub_state_e;

endpackage : bwd_pkg

/* File: rtl/bwd_window_match.sv */
`timescale 1ns/1ps
module bwd_window_match
(
    input wire logic i_enable,
    input wire bwd_pkg::bwd_window_s i_window,
    input wire bwd_pkg::bwd_txn_s i_txn,
    output logic o_hit
);
    import bwd_pkg::*;

    logic win_io;
    logic [31:0] lo;
    logic [31:0] hi;

    always_comb
    begin
        win_io = i_window.limit[LIMIT_IO_BIT];
        if (win_io)
        begin
            lo = {i_window.base[31:2], 2'h0};
            hi = {i_window.limit[31:2], 2'h3};
        end
        else
        begin
            // Memory: 4 KB grain, low limit bits read as ones
            lo = {i_window.base[31:12], 12'h000};
            hi = {i_window.limit[31:12], 12'hfff};
        end
        o_hit = i_enable && i_txn.valid && (i_txn.is_io == win_io)
            && (i_txn.addr >= lo) && (i_txn.addr <= hi);
    end

endmodule : bwd_window_match

/* File: rtl/bwd_axil_slave.sv */
`timescale 1ns/1ps
module bwd_axil_slave
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_wr_en,
    output logic [11:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic [3:0] o_wr_strb,
    input wire logic i_wr_ok,
    output logic o_rd_en,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_ok
);
    import bwd_pkg::*;

    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

    assign o_wr_en = aw_full_q && w_full_q && !bvalid_q;
    assign o_wr_addr = awaddr_q;
    assign o_wr_data = wdata_q;
    assign o_wr_strb = wstrb_q;
    assign o_rd_en = i_arvalid && arready_q;

    always_comb
    begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (i_awvalid && awready_q)
        begin
            aw_full_d = 1'b1;
            awaddr_d = i_awaddr;
        end
        if (i_wvalid && wready_q)
        begin
            w_full_d = 1'b1;
            wdata_d = i_wdata;
            wstrb_d = i_wstrb;
        end
        if (o_wr_en)
        begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = i_wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_q && i_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (o_rd_en)
        begin
            rvalid_d = 1'b1;
            rdata_d = i_rd_data;
            rresp_d = i_rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && i_rready)
        begin
            rvalid_d = 1'b0;
        end
        // One write and one read in flight at a time
        awready_d = !aw_full_d && !bvalid_d;
        wready_d = !w_full_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 12'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rresp = rresp_q;
    assign o_rdata = rdata_q;

endmodule : bwd_axil_slave

/* File: rtl/bwd_decode_top.sv */
// Contract
// - Window enable and map registers read zero in bits 7-2.
// - Secondary decode control reads zero in bits 7-3.
// - Enable bit 0 gates window 0 decode; resets to off.
// - Enable bit 1 gates window 1 decode; resets to off.
// - Map bit 0 clear includes window 0 in primary decode, set excludes.
// - Map bit 1 clear includes window 1 in primary decode, set excludes.
// - Negative decode on: secondary decode is complement of primary positive decode.
// - Negative decode off: excluded windows positively forward secondary to primary.
// - Upstream window decode is steered by the window map and the secondary decode control.
// - Window settings have no effect unless its enable bit is set.
// - Control bit 1 enables secondary negative decode; resets to on.
// - Negative decode on: all secondary cycles outside included windows go upstream.
// - Control bit 0 enables secondary subtractive claim; resets to off.
// - Subtractive: unclaimed secondary cycles forwarded at the decode slot.
// - Speed bit alone never enables subtractive decode.
// - Control bit 2 picks slow slot, four clocks after frame start.
// - Limit bits 1-0 give window type: memory, prefetchable, or I/O.
// - Memory windows 4 KB grain, I/O windows doubleword grain.
`timescale 1ns/1ps
module bwd_decode_top
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [11:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire bwd_pkg::bwd_txn_s i_pri_txn,
    input wire bwd_pkg::bwd_txn_s i_sec_txn,
    input wire logic i_sec_devsel,
    output logic o_pri_claim,
    output logic o_sec_fwd,
    output logic o_sec_sub_claim
);
    import bwd_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [31:0] rd_data;
    logic rd_ok;

    bwd_axil_slave u_slave
    (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_awaddr(i_s_axi_awaddr),
        .i_awvalid(i_s_axi_awvalid),
        .o_awready(o_s_axi_awready),
        .i_wdata(i_s_axi_wdata),
        .i_wstrb(i_s_axi_wstrb),
        .i_wvalid(i_s_axi_wvalid),
        .o_wready(o_s_axi_wready),
        .o_bresp(o_s_axi_bresp),
        .o_bvalid(o_s_axi_bvalid),
        .i_bready(i_s_axi_bready),
        .i_araddr(i_s_axi_araddr),
        .i_arvalid(i_s_axi_arvalid),
        .o_arready(o_s_axi_arready),
        .o_rdata(o_s_axi_rdata),
        .o_rresp(o_s_axi_rresp),
        .o_rvalid(o_s_axi_rvalid),
        .i_rready(i_s_axi_rready),
        .o_wr_en(wr_en),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb),
        .i_wr_ok(wr_ok),
        .o_rd_en(rd_en),
        .i_rd_data(rd_data),
        .i_rd_ok(rd_ok)
    );

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [1:0] win_en_q, win_en_d;
    logic [1:0] win_map_q, win_map_d;
    logic [2:0] sec_ctl_q, sec_ctl_d;
    bwd_window_s win_q [2];
    bwd_window_s win_d [2];
    logic [31:0] wmask;
    logic [2:0] status;

    function automatic logic [31:0] bwd_merge(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [31:0] mask);
        bwd_merge = (old_v & ~mask) | (new_v & mask);
    endfunction : bwd_merge

    always_comb
    begin
        wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
        win_en_d = win_en_q;
        win_map_d = win_map_q;
        sec_ctl_d = sec_ctl_q;
        win_d[0] = win_q[0];
        win_d[1] = win_q[1];
        wr_ok = 1'b1;
        if (wr_en)
        begin
            case (wr_addr)
                ADDR_WIN0_BASE:
                begin
                    win_d[0].base = bwd_merge(win_q[0].base, wr_data, wmask & BASE_RO_MASK);
                end
                ADDR_WIN0_LIMIT:
                begin
                    win_d[0].limit = bwd_merge(win_q[0].limit, wr_data, wmask);
                end
                ADDR_WIN1_BASE:
                begin
                    win_d[1].base = bwd_merge(win_q[1].base, wr_data, wmask & BASE_RO_MASK);
                end
                ADDR_WIN1_LIMIT:
                begin
                    win_d[1].limit = bwd_merge(win_q[1].limit, wr_data, wmask);
                end
                ADDR_WIN_ENABLE:
                begin
                    if (wr_strb[0])
                    begin
                        win_en_d = wr_data[1:0];
                    end
                end
                ADDR_WIN_MAP:
                begin
                    if (wr_strb[0])
                    begin
                        win_map_d = wr_data[1:0];
                    end
                end
                ADDR_SEC_DECODE:
                begin
                    if (wr_strb[0])
                    begin
                        sec_ctl_d = wr_data[2:0];
                    end
                end
                ADDR_DEC_STATUS:
                begin
                    wr_ok = 1'b1;
                end
                default:
                begin
                    wr_ok = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_en_q <= RST_WIN_ENABLE;
            win_map_q <= RST_WIN_MAP;
            sec_ctl_q <= RST_SEC_DECODE;
            win_q[0] <= '{base: RST_WIN_ADDR, limit: RST_WIN_ADDR};
            win_q[1] <= '{base: RST_WIN_ADDR, limit: RST_WIN_ADDR};
        end
        else
        begin
            win_en_q <= win_en_d;
            win_map_q <= win_map_d;
            sec_ctl_q <= sec_ctl_d;
            win_q[0] <= win_d[0];
            win_q[1] <= win_d[1];
        end
    end

    // Read mux; narrow registers pad with zeros
    always_comb
    begin
        rd_ok = 1'b1;
        rd_data = 32'h0;
        if (rd_en)
        begin
            case (i_s_axi_araddr)
                ADDR_WIN0_BASE: rd_data = win_q[0].base;
                ADDR_WIN0_LIMIT: rd_data = win_q[0].limit;
                ADDR_WIN1_BASE: rd_data = win_q[1].base;
                ADDR_WIN1_LIMIT: rd_data = win_q[1].limit;
                ADDR_WIN_ENABLE: rd_data = {30'h0, win_en_q};
                ADDR_WIN_MAP: rd_data = {30'h0, win_map_q};
                ADDR_SEC_DECODE: rd_data = {29'h0, sec_ctl_q};
                ADDR_DEC_STATUS: rd_data = {29'h0, status};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Window match
    // ------------------------------------------------------------
    logic [1:0] pri_hit;
    logic [1:0] sec_hit;

    for (genvar g = 0; g < 2; g++)
    begin : g_win
        // Disabled window never hits
        bwd_window_match u_pri
        (
            .i_enable(win_en_q[g]),
            .i_window(win_q[g]),
            .i_txn(i_pri_txn),
            .o_hit(pri_hit[g])
        );
        bwd_window_match u_sec
        (
            .i_enable(win_en_q[g]),
            .i_window(win_q[g]),
            .i_txn(i_sec_txn),
            .o_hit(sec_hit[g])
        );
    end

    // ------------------------------------------------------------
    // Decode decisions
    // ------------------------------------------------------------
    logic pri_claim_q, pri_claim_d;
    logic sec_fwd_q, sec_fwd_d;
    logic sec_down;
    logic sec_pos_up;

    always_comb
    begin
        pri_claim_d = i_pri_txn.valid && |(pri_hit & ~win_map_q);
        sec_down = |(sec_hit & ~win_map_q);
        sec_pos_up = |(sec_hit & win_map_q);
        sec_fwd_d = 1'b0;
        if (i_sec_txn.valid)
        begin
            if (sec_ctl_q[SEC_NEG_EN_BIT])
            begin
                sec_fwd_d = !sec_down;
            end
            else
            begin
                sec_fwd_d = sec_pos_up;
            end
        end
    end

    // ------------------------------------------------------------
    // Subtractive claim
    // ------------------------------------------------------------
    bwd_sub_state_e sub_state_q, sub_state_d;
    logic [2:0] sub_cnt_q, sub_cnt_d;
    logic [2:0] sub_slot_q, sub_slot_d;
    logic sub_claim_q, sub_claim_d;
    logic sub_seen_q, sub_seen_d;

    always_comb
    begin
        sub_state_d = sub_state_q;
        sub_cnt_d = sub_cnt_q;
        sub_slot_d = sub_slot_q;
        sub_claim_d = 1'b0;
        sub_seen_d = sub_seen_q;
        case (sub_state_q)
            SUB_IDLE:
            begin
                // Cycles the bridge already forwards or owns are skipped
                if (i_sec_txn.valid && sec_ctl_q[SEC_SUB_EN_BIT] && !sec_fwd_d
                    && !sec_down)
                begin
                    sub_state_d = SUB_WAIT;
                    sub_cnt_d = 3'h1;
                    sub_slot_d = sec_ctl_q[SEC_SLOW_BIT] ? SLOT_SLOW_CLKS
                        : SLOT_NORMAL_CLKS;
                    sub_seen_d = 1'b0;
                end
            end
            SUB_WAIT:
            begin
                if (i_sec_devsel)
                begin
                    sub_state_d = SUB_IDLE;
                end
                else if (sub_cnt_q == sub_slot_q - 3'h1)
                begin
                    sub_claim_d = 1'b1;
                    sub_seen_d = 1'b1;
                    sub_state_d = SUB_HOLD;
                end
                else
                begin
                    sub_cnt_d = sub_cnt_q + 3'h1;
                end
            end
            SUB_HOLD:
            begin
                sub_state_d = SUB_IDLE;
            end
            default:
            begin
                sub_state_d = SUB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pri_claim_q <= 1'b0;
            sec_fwd_q <= 1'b0;
            sub_state_q <= SUB_IDLE;
            sub_cnt_q <= 3'h0;
            sub_slot_q <= SLOT_SLOW_CLKS;
            sub_claim_q <= 1'b0;
            sub_seen_q <= 1'b0;
        end
        else
        begin
            pri_claim_q <= pri_claim_d;
            sec_fwd_q <= sec_fwd_d;
            sub_state_q <= sub_state_d;
            sub_cnt_q <= sub_cnt_d;
            sub_slot_q <= sub_slot_d;
            sub_claim_q <= sub_claim_d;
            sub_seen_q <= sub_seen_d;
        end
    end

    assign status = {sub_seen_q, sec_fwd_q, pri_claim_q};
    assign o_pri_claim = pri_claim_q;
    assign o_sec_fwd = sec_fwd_q;
    assign o_sec_sub_claim = sub_claim_q;

endmodule : bwd_decode_top

/* File: verif/bwd_decode_assertions.sv */
`timescale 1ns/1ps
module bwd_decode_checker
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [11:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic o_s_axi_rvalid,
    input wire bwd_pkg::bwd_txn_s i_pri_txn,
    input wire bwd_pkg::bwd_txn_s i_sec_txn,
    input wire logic i_sec_devsel,
    input wire logic o_pri_claim,
    input wire logic o_sec_fwd,
    input wire logic o_sec_sub_claim
);
    import bwd_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    a_claim_cause: assert property (o_pri_claim |-> $past(i_pri_txn.valid))
        else $error("primary claim without start");
    a_fwd_cause: assert property (o_sec_fwd |-> $past(i_sec_txn.valid))
        else $error("forward without start");
    a_sub_slot: assert property (o_sec_sub_claim |->
        $past(i_sec_txn.valid, 3) || $past(i_sec_txn.valid, 4))
        else $error("claim off the decode slot");
    a_sub_devsel: assert property (o_sec_sub_claim |-> !$past(i_sec_devsel))
        else $error("claim after another target");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    a_read_refuse: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read taken while answer pending");
    a_rsv_enable: assert property ($rose(o_s_axi_rvalid) &&
        $past(i_s_axi_araddr) == ADDR_WIN_ENABLE |-> o_s_axi_rdata[31:2] == 30'h0)
        else $error("enable reserved bits set");
    a_rsv_map: assert property ($rose(o_s_axi_rvalid) &&
        $past(i_s_axi_araddr) == ADDR_WIN_MAP |-> o_s_axi_rdata[31:2] == 30'h0)
        else $error("map reserved bits set");
    a_rsv_sec: assert property ($rose(o_s_axi_rvalid) &&
        $past(i_s_axi_araddr) == ADDR_SEC_DECODE |-> o_s_axi_rdata[31:3] == 29'h0)
        else $error("control reserved bits set");
endmodule : bwd_decode_checker

bind bwd_decode_top bwd_decode_checker u_chk (.i_clk, .i_reset_n, .i_s_axi_araddr,
    .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid, .i_pri_txn,
    .i_sec_txn, .i_sec_devsel, .o_pri_claim, .o_sec_fwd, .o_sec_sub_claim);

/* File: verif/bwd_pci_agents.sv */
`timescale 1ns/1ps
module bwd_pci_agents
(
    input wire logic i_clk,
    output bwd_pkg::bwd_txn_s o_pri_txn,
    output bwd_pkg::bwd_txn_s o_sec_txn,
    output logic o_sec_devsel
);
    import bwd_pkg::*;
    initial
    begin
        o_pri_txn = '0;
        o_sec_txn = '0;
        o_sec_devsel = 1'b0;
    end
    // Released lines show the inverse, never the last address
    task automatic pri_go(input logic [31:0] a, input logic io);
        @(posedge i_clk);
        o_pri_txn <= '{1'b1, io, a};
        @(posedge i_clk);
        o_pri_txn <= '{1'b0, ~io, ~a};
    endtask : pri_go
    task automatic sec_go(input logic [31:0] a, input logic io, input logic dv);
        @(posedge i_clk);
        o_sec_txn <= '{1'b1, io, a};
        o_sec_devsel <= 1'b0;
        @(posedge i_clk);
        o_sec_txn <= '{1'b0, ~io, ~a};
        o_sec_devsel <= dv;
    endtask : sec_go
endmodule : bwd_pci_agents

/* File: verif/bridge_window_decode_control_test.sv */
`timescale 1ns/1ps
module bridge_window_decode_control_test;
    import bwd_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic awr, wr_r, bv, arr, rv, pcl, sfw, scl, dvs;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    bwd_txn_s ptx, stx;
    int n_mismatch = 0, check_count = 0;
    always #50 i_clk = ~i_clk;
    bwd_pci_agents agents (.i_clk(i_clk), .o_pri_txn(ptx), .o_sec_txn(stx), .o_sec_devsel(dvs));
    bwd_decode_top uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_s_axi_awaddr(awa),
        .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd),
        .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_r),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv), .i_s_axi_bready(br),
        .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv),
        .i_s_axi_rready(rr), .i_pri_txn(ptx), .i_sec_txn(stx), .i_sec_devsel(dvs),
        .o_pri_claim(pcl), .o_sec_fwd(sfw), .o_sec_sub_claim(scl));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    task automatic tmo(input int n);
        if (n >= 40)
        begin
            chk("timeout", 0, n);
            summarize();
        end
    endtask : tmo
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge i_clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
            n++;
        end while (bv !== 1'b1 && n < 40);
        br <= 1'b0;
        tmo(n);
        chk("bresp", er, bresp);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge i_clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            if (arr) arv <= 1'b0;
            n++;
        end while (rv !== 1'b1 && n < 40);
        rr <= 1'b0;
        tmo(n);
        chk("rdata", e, rdata);
        chk("rresp", er, rresp);
    endtask : rd
    task automatic pri(input logic [31:0] a, input logic io, input logic e);
        agents.pri_go(a, io);
        #1;
        chk("pri_claim", e, pcl);
    endtask : pri
    task automatic sec(input logic [31:0] a, input logic io, input logic dv, input logic f,
        input int sl);
        int k, got;
        agents.sec_go(a, io, dv);
        #1;
        chk("sec_fwd", f, sfw);
        got = 0;
        for (k = 1; k < 7; k++)
        begin
            if (scl === 1'b1 && got == 0) got = k;
            @(posedge i_clk);
            #1;
        end
        chk("sub_slot", sl, got);
    endtask : sec
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(ADDR_WIN_ENABLE, 32'h0, RESP_OKAY);
        rd(ADDR_WIN_MAP, 32'h0, RESP_OKAY);
        rd(ADDR_SEC_DECODE, 32'h6, RESP_OKAY);
        $display("test reset done");
        wr(ADDR_WIN_ENABLE, 32'hffffffff, RESP_OKAY);
        wr(ADDR_WIN_MAP, 32'hffffffff, RESP_OKAY);
        wr(ADDR_SEC_DECODE, 32'hffffffff, RESP_OKAY);
        rd(ADDR_WIN_ENABLE, 32'h3, RESP_OKAY);
        rd(ADDR_WIN_MAP, 32'h3, RESP_OKAY);
        rd(ADDR_SEC_DECODE, 32'h7, RESP_OKAY);
        wr(12'hffc, 32'h1, RESP_SLVERR);
        rd(12'hffc, 32'h0, RESP_SLVERR);
        $display("test registers done");
        wr(ADDR_WIN_ENABLE, 32'h0, RESP_OKAY);
        wr(ADDR_WIN_MAP, 32'h0, RESP_OKAY);
        wr(ADDR_SEC_DECODE, 32'h6, RESP_OKAY);
        wr(ADDR_WIN0_BASE, 32'h10000, RESP_OKAY);
        wr(ADDR_WIN0_LIMIT, 32'h10000, RESP_OKAY);
        wr(ADDR_WIN1_BASE, 32'h2000, RESP_OKAY);
        wr(ADDR_WIN1_LIMIT, 32'h2006, RESP_OKAY);
        pri(32'h10ffc, 1'b0, 1'b0);
        sec(32'h10ffc, 1'b0, 1'b0, 1'b1, 0);
        wr(ADDR_WIN_ENABLE, 32'h3, RESP_OKAY);
        pri(32'h10ffc, 1'b0, 1'b1);
        pri(32'h11000, 1'b0, 1'b0);
        pri(32'h10ffc, 1'b1, 1'b0);
        pri(32'h2004, 1'b1, 1'b1);
        pri(32'h2008, 1'b1, 1'b0);
        sec(32'h10ffc, 1'b0, 1'b0, 1'b0, 0);
        sec(32'h11000, 1'b0, 1'b0, 1'b1, 0);
        $display("test include done");
        wr(ADDR_WIN_MAP, 32'h1, RESP_OKAY);
        wr(ADDR_SEC_DECODE, 32'h0, RESP_OKAY);
        pri(32'h10ffc, 1'b0, 1'b0);
        sec(32'h10ffc, 1'b0, 1'b0, 1'b1, 0);
        sec(32'h11000, 1'b0, 1'b0, 1'b0, 0);
        wr(ADDR_WIN_MAP, 32'h3, RESP_OKAY);
        pri(32'h2004, 1'b1, 1'b0);
        $display("test exclude done");
        wr(ADDR_WIN_MAP, 32'h0, RESP_OKAY);
        wr(ADDR_SEC_DECODE, 32'h1, RESP_OKAY);
        sec(32'h11000, 1'b0, 1'b0, 1'b0, 3);
        rd(ADDR_DEC_STATUS, 32'h4, RESP_OKAY);
        wr(ADDR_SEC_DECODE, 32'h5, RESP_OKAY);
        sec(32'h11000, 1'b0, 1'b0, 1'b0, 4);
        sec(32'h11000, 1'b0, 1'b1, 1'b0, 0);
        sec(32'h10ffc, 1'b0, 1'b0, 1'b0, 0);
        wr(ADDR_SEC_DECODE, 32'h4, RESP_OKAY);
        sec(32'h11000, 1'b0, 1'b0, 1'b0, 0);
        $display("test subtractive done");
        summarize();
    end
endmodule : bridge_window_decode_control_test
